// [hw/srld_regs.svh]
// Timing counts and bit map constants for the serial relay latch driver
`ifndef SRLD_REGS_SVH
`define SRLD_REGS_SVH

// --------------------------------------------------------------------
// Chain geometry
// --------------------------------------------------------------------
`define SRLD_STAGE_BITS      8
`define SRLD_STAGE_COUNT     3
`define SRLD_CHAIN_BITS      24

// --------------------------------------------------------------------
// Relay bit mapping inside the latched word
// --------------------------------------------------------------------
`define SRLD_INPUT_LSB       0
`define SRLD_INPUT_COUNT     12
`define SRLD_POLE_BIT        12
`define SRLD_USED_MASK       24'h001FFF

// --------------------------------------------------------------------
// Reset values
// --------------------------------------------------------------------
`define SRLD_CHAIN_RESET     24'h000000
`define SRLD_DRIVE_OFF       13'h1FFF

// --------------------------------------------------------------------
// Power supervisor hold time after the supply is reported good
// --------------------------------------------------------------------
`define SRLD_CLOCK_MHZ       10
`define SRLD_PWR_HOLD_US     20
`define SRLD_PWR_HOLD_CYC    (`SRLD_PWR_HOLD_US * `SRLD_CLOCK_MHZ)

`endif

// [hw/srld_pkg.sv]
// Types shared by the serial relay latch driver
package srld_pkg;

  // Power supervisor states
  typedef enum logic [1:0]
  {
    SRLD_PWR_OFF,
    SRLD_PWR_HOLD,
    SRLD_PWR_ON
  } srld_pwr_state_t;

endpackage

// [hw/srld_top.sv]
// Serial relay latch driver: shift chain, output latch, power supervisor
//
// What this block does
// - Update is exactly three bytes, serially shifted
// - Data bit captured on each serial clock
// - Stage overflow feeds next stage serial input
// - Strobe high transfers chain into output latch
// - Driver outputs low energize their relays
// - Disabled outputs energize no relay at all
// - Supervisor blocks actuation during power transitions
// - Enable active low, held high during transition
// - One bit selects 2-pole or 4-pole configuration
// - Twelve bits each drive one input relay
`timescale 1ns/1ps
`default_nettype none
`include "srld_regs.svh"

module srld_top
#(
  parameter int STAGE_BITS  = `SRLD_STAGE_BITS,
  parameter int STAGE_COUNT = `SRLD_STAGE_COUNT,
  parameter int HOLD_CYC    = `SRLD_PWR_HOLD_CYC
)
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        serial_clk,
  input  wire logic        serial_data,
  input  wire logic        strobe,
  input  wire logic        supply_good,
  output var  logic        cascade_out,
  output var  logic        output_enable_n,
  output var  logic [11:0] input_relay_n,
  output var  logic        pole_config_relay_n
);

  // ------------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------------
  localparam int CHAIN = STAGE_BITS * STAGE_COUNT;

  // Relay bit map is fixed for a 24-bit chain, so refuse anything else
  if (CHAIN != `SRLD_CHAIN_BITS)
    $error("srld_top: chain must be 24 bits");
  if (HOLD_CYC < 1)
    $error("srld_top: HOLD_CYC must be at least 1");

  // ------------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------------
  logic rst_meta_reg;                   // First reset stage
  logic rst_n_reg;                      // Released reset used below

  // Assert at once, release two clocks later
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  logic [3:0] pin_meta_reg;             // First stage, read by stage two only
  logic [3:0] pin_sync_reg;             // Safe copies of the pins
  logic       sclk_last_reg;            // Serial clock one cycle ago

  // Two flops per pin since all four are asynchronous to the system clock
  always_ff @(posedge clock or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      pin_meta_reg  <= 4'h0;
      pin_sync_reg  <= 4'h0;
      sclk_last_reg <= 1'b0;
    end
    else
    begin
      pin_meta_reg  <= {supply_good, strobe, serial_data, serial_clk};
      pin_sync_reg  <= pin_meta_reg;
      sclk_last_reg <= pin_sync_reg[0];
    end
  end

  wire sclk_s   = pin_sync_reg[0];      // Synchronised serial clock
  wire data_s   = pin_sync_reg[1];      // Synchronised data bit
  wire strobe_s = pin_sync_reg[2];      // Synchronised strobe level
  wire good_s   = pin_sync_reg[3];      // Synchronised supply status

  // Rising serial clock: data was set up a full host half period before
  wire shift_en = sclk_s & ~sclk_last_reg;

  // ------------------------------------------------------------------
  // Shift chain: three cascaded eight-bit stages
  // ------------------------------------------------------------------
  logic [CHAIN-1:0] chain_reg;          // Serial shift path
  logic [CHAIN-1:0] chain_next;         // Chain after one shift
  logic [STAGE_COUNT:0] link;           // Stage serial inputs and overflows

  assign link[0] = data_s;

  // Each stage after the first shifts in from the previous stage's overflow bit
  for (genvar s = 0; s < STAGE_COUNT; s++)
  begin : g_stage
    assign chain_next[s*STAGE_BITS +: STAGE_BITS] =
      {chain_reg[s*STAGE_BITS +: STAGE_BITS-1], link[s]};
    assign link[s+1] = chain_reg[s*STAGE_BITS + STAGE_BITS - 1];
  end

  // One bit per serial clock edge; 24 edges load a full update
  always_ff @(posedge clock or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      chain_reg <= `SRLD_CHAIN_RESET;
    else if (shift_en)
      chain_reg <= chain_next;
  end

  // ------------------------------------------------------------------
  // Output latch
  // ------------------------------------------------------------------
  logic [CHAIN-1:0] latch_reg;          // Relay pattern in force

  // Transparent while strobe is high, holds otherwise
  always_ff @(posedge clock or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      latch_reg <= `SRLD_CHAIN_RESET;
    else if (strobe_s)
      latch_reg <= chain_reg;
  end

  // ------------------------------------------------------------------
  // Power supervisor
  // ------------------------------------------------------------------
  srld_pkg::srld_pwr_state_t pwr_reg;   // Supervisor state
  srld_pkg::srld_pwr_state_t pwr_next;  // Next supervisor state
  logic [31:0] hold_reg;                // Cycles spent in hold; zero in other states
  logic [31:0] hold_next;               // Next hold count

  wire hold_done = (hold_reg >= 32'(HOLD_CYC - 1));

  // Supply must stay good for the hold time before relays may move
  always_comb
  begin
    pwr_next  = pwr_reg;
    hold_next = 32'h0000_0000;
    case (pwr_reg)
      srld_pkg::SRLD_PWR_OFF:
        if (good_s)
          pwr_next = srld_pkg::SRLD_PWR_HOLD;
      srld_pkg::SRLD_PWR_HOLD:
        if (!good_s)
          pwr_next = srld_pkg::SRLD_PWR_OFF;
        else if (hold_done)
          pwr_next = srld_pkg::SRLD_PWR_ON;
        else
          hold_next = hold_reg + 32'h0000_0001;
      srld_pkg::SRLD_PWR_ON:
        if (!good_s)
          pwr_next = srld_pkg::SRLD_PWR_OFF;
      default:
        pwr_next = srld_pkg::SRLD_PWR_OFF;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      pwr_reg  <= srld_pkg::SRLD_PWR_OFF;
      hold_reg <= 32'h0000_0000;
    end
    else
    begin
      pwr_reg  <= pwr_next;
      hold_reg <= hold_next;
    end
  end

  // Enabled only in steady power; drop happens the cycle good falls
  wire enable_next = (pwr_next == srld_pkg::SRLD_PWR_ON);

  // ------------------------------------------------------------------
  // Relay drive
  // ------------------------------------------------------------------
  // Bits 0..11 input relays, bit 12 pole select, 13..23 unused
  wire [CHAIN-1:0] used_bits = latch_reg & `SRLD_USED_MASK;
  wire [11:0] input_drive_n =
    enable_next ? ~used_bits[`SRLD_INPUT_LSB +: `SRLD_INPUT_COUNT]
                : 12'hFFF;
  wire pole_drive_n =
    enable_next ? ~used_bits[`SRLD_POLE_BIT] : 1'b1;

  // All outputs registered; relays off and disabled through reset
  always_ff @(posedge clock or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      output_enable_n     <= 1'b1;
      input_relay_n       <= 12'hFFF;
      pole_config_relay_n <= 1'b1;
      cascade_out         <= 1'b0;
    end
    else
    begin
      output_enable_n     <= ~enable_next;
      input_relay_n       <= input_drive_n;
      pole_config_relay_n <= pole_drive_n;
      cascade_out         <= chain_reg[CHAIN-1];
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  disabled_relays_off_a:
    assert property (@(posedge clock) disable iff (!rst_n_reg)
      output_enable_n |-> (input_relay_n == 12'hFFF) && pole_config_relay_n)
    else $error("relay energized while outputs disabled");

  supply_drop_off_a:
    assert property (@(posedge clock) disable iff (!rst_n_reg)
      !good_s |=> output_enable_n)
    else $error("outputs enabled during power transition");

  powerup_hold_a:
    assert property (@(posedge clock) disable iff (!rst_n_reg)
      $rose(good_s) |=> output_enable_n[*2])
    else $error("outputs enabled too soon after power good");

  shift_on_edge_a:
    assert property (@(posedge clock) disable iff (!rst_n_reg)
      shift_en |=> chain_reg[0] == $past(data_s))
    else $error("data bit not captured on serial clock");

  stage_cascade_a:
    assert property (@(posedge clock) disable iff (!rst_n_reg)
      shift_en |=> chain_reg[8] == $past(chain_reg[7]) &&
                   chain_reg[16] == $past(chain_reg[15]))
    else $error("stage overflow not passed down the chain");

  chain_quiet_a:
    assert property (@(posedge clock) disable iff (!rst_n_reg)
      !shift_en |=> $stable(chain_reg))
    else $error("chain moved without serial clock");

  latch_hold_a:
    assert property (@(posedge clock) disable iff (!rst_n_reg)
      !strobe_s |=> $stable(latch_reg))
    else $error("latch changed without strobe");

  strobe_load_a:
    assert property (@(posedge clock) disable iff (!rst_n_reg)
      strobe_s |=> latch_reg == $past(chain_reg))
    else $error("strobe did not load the chain");

  active_low_a:
    assert property (@(posedge clock) disable iff (!rst_n_reg)
      enable_next |=> input_relay_n == ~$past(latch_reg[11:0]) &&
                      pole_config_relay_n == ~$past(latch_reg[12]))
    else $error("relay drive not active low of latch");

endmodule
`default_nettype wire

// [dv/srld_host_model.sv]
// Host side model: shifts relay words in and pulses the strobe
`timescale 1ns/1ps
`default_nettype none

module srld_host_model
(
  input  wire logic clock,
  output var  logic serial_clk,
  output var  logic serial_data,
  output var  logic strobe
);
  // --------------------------------------------------------------
  // Link idle levels
  // --------------------------------------------------------------
  initial
  begin
    serial_clk  = 1'b0;
    serial_data = 1'b0;
    strobe      = 1'b0;
  end

  // Wait a number of falling system clock edges
  task automatic ticks(input int n);
    repeat (n) @(negedge clock);
  endtask

  // Shift nb bits, top bit first; 800 ns link period, still between
  task automatic send(input logic [23:0] w, input int nb);
    for (int i = nb - 1; i >= 0; i--)
    begin
      serial_data = w[i];
      ticks(4);
      serial_clk = 1'b1;
      ticks(4);
      serial_clk = 1'b0;
    end
    // Line released: show the inverse, never the stale bit
    serial_data = ~serial_data;
  endtask

  // Strobe only after the whole word, with the link clock idle
  task automatic pulse();
    ticks(2);
    strobe = 1'b1;
    ticks(4);
    strobe = 1'b0;
  endtask
endmodule

`default_nettype wire

// [dv/serial_relay_latch_driver_tb_top.sv]
// Self-checking bench for the serial relay latch driver
`timescale 1ns/1ps
`default_nettype none

module serial_relay_latch_driver_tb_top;
  // Short supervisor hold keeps the run brief
  localparam int HOLD = 4;

  logic        clock;
  logic        reset_n;
  logic        supply_good;
  wire  logic  serial_clk;
  wire  logic  serial_data;
  wire  logic  strobe;
  wire  logic  cascade_out;
  wire  logic  output_enable_n;
  wire  logic  pole_config_relay_n;
  wire  logic [11:0] input_relay_n;
  logic [12:0] shown;      // Relay drive expected right now
  int          n_errors = 0;
  int          checked = 0;
  int          cycles = 0;

  // --------------------------------------------------------------
  // Instances
  // --------------------------------------------------------------
  srld_top #(.HOLD_CYC(HOLD)) i_srld_top
  (
    .clock               (clock),
    .reset_n             (reset_n),
    .serial_clk          (serial_clk),
    .serial_data         (serial_data),
    .strobe              (strobe),
    .supply_good         (supply_good),
    .cascade_out         (cascade_out),
    .output_enable_n     (output_enable_n),
    .input_relay_n       (input_relay_n),
    .pole_config_relay_n (pole_config_relay_n)
  );

  srld_host_model i_srld_host_model
  (
    .clock       (clock),
    .serial_clk  (serial_clk),
    .serial_data (serial_data),
    .strobe      (strobe)
  );

  // 100 ns system clock
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Hang guard: the tests need well under this many cycles
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      wrap_up();
    end
  end

  // --------------------------------------------------------------
  // Compare and closing tasks
  // --------------------------------------------------------------
  task automatic chk_drive(input logic [12:0] exp);
    checked++;
    if ({pole_config_relay_n, input_relay_n} !== exp)
    begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time,
               {pole_config_relay_n, input_relay_n}, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("errors=%0d checks=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  // Outputs stay off until the supply has been good for the hold
  task automatic t_power_up();
    chk_bit(output_enable_n, 1'b1);
    chk_drive(13'h1FFF);
    supply_good = 1'b1;
    i_srld_host_model.ticks(3);
    chk_bit(output_enable_n, 1'b1);
    i_srld_host_model.ticks(HOLD + 8);
    chk_bit(output_enable_n, 1'b0);
    shown = 13'h1FFF;
    chk_drive(shown);
  endtask

  // One word: old pattern holds while shifting, strobe shows new one
  task automatic t_load(input logic [23:0] w, input logic on);
    i_srld_host_model.send(w, 24);
    i_srld_host_model.ticks(2);
    chk_drive(shown);
    chk_bit(cascade_out, w[23]);
    i_srld_host_model.pulse();
    i_srld_host_model.ticks(4);
    if (on)
      shown = ~w[12:0];
    chk_drive(shown);
  endtask

  // Back-to-back words; high unused bits must stay inert
  task automatic t_loads();
    t_load(24'hFFE000, 1'b1);
    t_load(24'h001AAA, 1'b1);
    t_load(24'h800555, 1'b1);
    t_load(24'h7FF000, 1'b1);
  endtask

  // Supply loss blanks drives; latch still loads, shown once good
  task automatic t_supply_drop();
    supply_good = 1'b0;
    i_srld_host_model.ticks(4);
    chk_bit(output_enable_n, 1'b1);
    shown = 13'h1FFF;
    chk_drive(shown);
    t_load(24'h000F0F, 1'b0);
    supply_good = 1'b1;
    i_srld_host_model.ticks(HOLD + 8);
    chk_bit(output_enable_n, 1'b0);
    chk_drive(13'h10F0);
  endtask

  // Main sequence
  initial
  begin
    reset_n     = 1'b0;
    supply_good = 1'b0;
    repeat (4) @(negedge clock);
    reset_n = 1'b1;
    repeat (8) @(negedge clock);
    t_power_up();
    t_loads();
    t_supply_drop();
    wrap_up();
  end
endmodule

`default_nettype wire
